/* File: rtl/adc_cmp_pkg.sv */
// Constants shared by the threshold-compare control block
package adc_cmp_pkg;
  localparam int          RESULT_W      = 12;
  localparam int          REG_W         = 16;
  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK  = 16'hF30F;
  localparam int          SCAN_EN_BIT   = 15;
  localparam int          LOW_PWR_BIT   = 14;
  localparam int          CTU_REQ_BIT   = 13;
  localparam int          BG_REQ_BIT    = 12;
  localparam int          IRQ_MODE_LSB  = 8;
  localparam int          WMODE_LSB     = 2;
  localparam int          CMODE_LSB     = 0;
  localparam int          ST_SEEN_BIT   = 0;
  localparam int          ST_MATCH_BIT  = 1;
  localparam int          ST_BG_BIT     = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    WM_LEGACY   = 2'h0,
    WM_SAVE_HIT = 2'h1,
    WM_CMP_ONLY = 2'h2,
    WM_RESERVED = 2'h3
  } write_mode_t;

  typedef enum logic [1:0] {
    CM_LESS    = 2'h0,
    CM_GREATER = 2'h1,
    CM_INSIDE  = 2'h2,
    CM_OUTSIDE = 2'h3
  } compare_mode_t;

  typedef enum logic [1:0] {
    IRQ_NONE      = 2'h0,
    IRQ_SCAN_DONE = 2'h1,
    IRQ_ON_MATCH  = 2'h2,
    IRQ_SCAN_HIT  = 2'h3
  } irq_mode_t;
endpackage : adc_cmp_pkg

/* File: rtl/compare_if.sv */
// Carrier between the control block and its comparator
interface compare_if;
  logic [adc_cmp_pkg::RESULT_W-1:0] result;
  logic [adc_cmp_pkg::RESULT_W-1:0] thresh_lo;
  logic [adc_cmp_pkg::RESULT_W-1:0] thresh_hi;
  adc_cmp_pkg::compare_mode_t       mode;
  logic                             match;

  modport ctrl (output result, output thresh_lo, output thresh_hi,
                output mode, input match);
  modport unit (input result, input thresh_lo, input thresh_hi,
                input mode, output match);
endinterface : compare_if

/* File: rtl/compare_unit.sv */
// Threshold comparator selected by the compare mode
module compare_unit (
  compare_if.unit cmp
);
  logic below;
  logic above;

  assign below = cmp.result < cmp.thresh_lo;
  assign above = cmp.result > cmp.thresh_hi;

  always_comb begin
    unique case (cmp.mode)
      adc_cmp_pkg::CM_OUTSIDE: cmp.match = below | above;
      adc_cmp_pkg::CM_INSIDE:  cmp.match = ~below & ~above;
      adc_cmp_pkg::CM_GREATER: cmp.match = cmp.result > cmp.thresh_lo;
      adc_cmp_pkg::CM_LESS:    cmp.match = below;
    endcase
  end
endmodule : compare_unit

/* File: rtl/adc_threshold_compare_control.sv */
// Converter threshold-compare and scan control with AXI4-Lite registers
// Notes on behaviour
// - Band gap on when requested, enabled, active
// - Compare-only stores nothing; interrupts still follow the IRQ mode field
// - Mode 01 stores on match, 00 always
// - Compare mode picks less/greater/inside/outside test
module adc_threshold_compare_control (
  input  wire logic                             clock,
  input  wire logic                             reset,
  input  wire logic [31:0]                      s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [31:0]                      s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             adc_enabled,
  input  wire logic                             adc_active,
  input  wire logic                             result_valid,
  input  wire logic [adc_cmp_pkg::RESULT_W-1:0] result_data,
  input  wire logic [adc_cmp_pkg::RESULT_W-1:0] thresh_lo,
  input  wire logic [adc_cmp_pkg::RESULT_W-1:0] thresh_hi,
  input  wire logic                             scan_done,
  output logic                                  bandgap_enable,
  output logic                                  store_strobe,
  output logic [adc_cmp_pkg::RESULT_W-1:0]      store_data,
  output logic                                  compare_irq
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]                      ctrl_r;
  logic                             awready_r;
  logic                             wready_r;
  logic                             aw_got_r;
  logic                             w_got_r;
  logic [31:0]                      awaddr_r;
  logic [31:0]                      wdata_r;
  logic [3:0]                       wstrb_r;
  logic                             bvalid_r;
  logic [1:0]                       bresp_r;
  logic                             arready_r;
  logic                             rvalid_r;
  logic [31:0]                      rdata_r;
  logic [1:0]                       rresp_r;
  logic                             bandgap_r;
  logic                             store_r;
  logic [adc_cmp_pkg::RESULT_W-1:0] store_data_r;
  logic                             irq_r;
  logic                             seen_r;
  logic                             last_match_r;
  logic                             commit;
  logic [15:0]                      wr_bits;
  logic                             bandgap_request;
  adc_cmp_pkg::write_mode_t         result_write_mode;
  adc_cmp_pkg::irq_mode_t           scan_irq_mode;
  logic                             hit;

  compare_if cmp ();

  compare_unit u_compare (
    .cmp (cmp)
  );

  assign bandgap_request   = ctrl_r[adc_cmp_pkg::BG_REQ_BIT];
  assign result_write_mode = adc_cmp_pkg::write_mode_t'(
           ctrl_r[adc_cmp_pkg::WMODE_LSB +: 2]);
  assign scan_irq_mode     = adc_cmp_pkg::irq_mode_t'(
           ctrl_r[adc_cmp_pkg::IRQ_MODE_LSB +: 2]);
  assign cmp.mode          = adc_cmp_pkg::compare_mode_t'(
           ctrl_r[adc_cmp_pkg::CMODE_LSB +: 2]);
  assign cmp.result        = result_data;
  assign cmp.thresh_lo     = thresh_lo;
  assign cmp.thresh_hi     = thresh_hi;
  assign hit               = result_valid & cmp.match;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign commit = aw_got_r & w_got_r & ~bvalid_r;
  always_comb begin
    wr_bits = ctrl_r;
    if (wstrb_r[0]) begin
      wr_bits[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      wr_bits[15:8] = wdata_r[15:8];
    end
    wr_bits = wr_bits & adc_cmp_pkg::CTRL_WR_MASK;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b0;
      awaddr_r  <= 32'h0000_0000;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (commit) begin
      aw_got_r  <= 1'b0;
    end else if (!aw_got_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (commit) begin
      w_got_r  <= 1'b0;
    end else if (!w_got_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r  <= adc_cmp_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r[31:2] == adc_cmp_pkg::CTRL_OFFSET[31:2] ||
                   awaddr_r[31:2] == adc_cmp_pkg::STATUS_OFFSET[31:2]) ?
                  adc_cmp_pkg::RESP_OKAY : adc_cmp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r <= adc_cmp_pkg::CTRL_RESET;
    end else if (commit &&
                 awaddr_r[31:2] == adc_cmp_pkg::CTRL_OFFSET[31:2]) begin
      ctrl_r <= wr_bits;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= adc_cmp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= adc_cmp_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      if (s_axi_araddr[31:2] == adc_cmp_pkg::CTRL_OFFSET[31:2]) begin
        rdata_r[15:0] <= ctrl_r;
      end else if (s_axi_araddr[31:2] ==
                   adc_cmp_pkg::STATUS_OFFSET[31:2]) begin
        rdata_r[adc_cmp_pkg::ST_SEEN_BIT]  <= seen_r;
        rdata_r[adc_cmp_pkg::ST_MATCH_BIT] <= last_match_r;
        rdata_r[adc_cmp_pkg::ST_BG_BIT]    <= bandgap_r;
      end else begin
        rresp_r <= adc_cmp_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Band gap, result store and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      bandgap_r <= 1'b0;
    end else begin
      bandgap_r <= bandgap_request & adc_enabled & adc_active;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      store_r      <= 1'b0;
      store_data_r <= '0;
      last_match_r <= 1'b0;
    end else begin
      store_r <= 1'b0;
      if (result_valid) begin
        last_match_r <= cmp.match;
        unique case (result_write_mode)
          adc_cmp_pkg::WM_LEGACY:   store_r <= 1'b1;
          adc_cmp_pkg::WM_SAVE_HIT: store_r <= cmp.match;
          adc_cmp_pkg::WM_CMP_ONLY: store_r <= 1'b0;
          adc_cmp_pkg::WM_RESERVED: store_r <= 1'b0;
        endcase
        store_data_r <= result_data;
      end
    end
  end

  // Match seen during the current scan; scan end clears it, even with a match in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      seen_r <= 1'b0;
    end else if (scan_done) begin
      seen_r <= 1'b0;
    end else if (hit) begin
      seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      unique case (scan_irq_mode)
        adc_cmp_pkg::IRQ_NONE:      irq_r <= 1'b0;
        adc_cmp_pkg::IRQ_SCAN_DONE: irq_r <= scan_done;
        adc_cmp_pkg::IRQ_ON_MATCH:  irq_r <= hit;
        adc_cmp_pkg::IRQ_SCAN_HIT:  irq_r <= scan_done & (seen_r | hit);
      endcase
    end
  end

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign bandgap_enable = bandgap_r;
  assign store_strobe   = store_r;
  assign store_data     = store_data_r;
  assign compare_irq    = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_BANDGAP_FOLLOWS: assert property (
    bandgap_enable == $past(bandgap_request & adc_enabled & adc_active))
    else $error("Band gap enable wrong");
  AST_CMP_ONLY_NO_STORE: assert property (
    result_valid && result_write_mode == adc_cmp_pkg::WM_CMP_ONLY
    |=> !store_strobe)
    else $error("Store in compare-only mode");
  AST_MATCH_IRQ: assert property (
    hit && scan_irq_mode == adc_cmp_pkg::IRQ_ON_MATCH |=> compare_irq)
    else $error("Missing match interrupt");
  AST_LEGACY_STORE: assert property (
    result_valid && result_write_mode == adc_cmp_pkg::WM_LEGACY
    |=> store_strobe && store_data == $past(result_data))
    else $error("Legacy store missing");
  AST_SAVE_ON_HIT: assert property (
    result_valid && result_write_mode == adc_cmp_pkg::WM_SAVE_HIT
    |=> store_strobe == $past(cmp.match))
    else $error("Save-on-match wrong");
  AST_GREATER: assert property (
    cmp.mode == adc_cmp_pkg::CM_GREATER
    |-> cmp.match == (cmp.result > cmp.thresh_lo))
    else $error("Greater test wrong");
  AST_INSIDE: assert property (
    cmp.mode == adc_cmp_pkg::CM_INSIDE |-> cmp.match ==
    (cmp.result >= cmp.thresh_lo && cmp.result <= cmp.thresh_hi))
    else $error("Inside test wrong");
  AST_NO_IRQ_MODE: assert property (
    compare_irq |-> $past(scan_irq_mode) != adc_cmp_pkg::IRQ_NONE)
    else $error("Interrupt while disabled");
  AST_SCAN_IRQ: assert property (
    scan_done && scan_irq_mode == adc_cmp_pkg::IRQ_SCAN_DONE |=> compare_irq)
    else $error("Missing scan interrupt");
  AST_SCAN_MATCH_IRQ: assert property (
    scan_done && scan_irq_mode == adc_cmp_pkg::IRQ_SCAN_HIT &&
    (seen_r || hit) |=> compare_irq)
    else $error("Missing scan-with-match interrupt");
  AST_OUTSIDE: assert property (
    cmp.mode == adc_cmp_pkg::CM_OUTSIDE |-> cmp.match ==
    (cmp.result < cmp.thresh_lo || cmp.result > cmp.thresh_hi))
    else $error("Outside test wrong");
endmodule : adc_threshold_compare_control

/* File: bench/adc_threshold_compare_control_bench.sv */
// Self-checking bench for the threshold-compare control block
module adc_threshold_compare_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [11:0] LO = 12'h064;
  localparam logic [11:0] HI = 12'h0C8;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        en = 0, act = 0, result_valid = 0, scan_done = 0;
  logic [11:0] result_data = '0, store_data;
  logic        bandgap_enable, store_strobe, compare_irq;
  logic [11:0] vals [4] = '{12'h063, 12'h064, 12'h0C8, 12'h0C9};
  int          num_errors = 0;
  int          compares = 0;

  always #2 clock = ~clock;

  adc_threshold_compare_control i_dut (
    .clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .adc_enabled(en), .adc_active(act), .result_valid(result_valid),
    .result_data(result_data), .thresh_lo(LO), .thresh_hi(HI),
    .scan_done(scan_done), .bandgap_enable(bandgap_enable),
    .store_strobe(store_strobe), .store_data(store_data),
    .compare_irq(compare_irq)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("Errors: %0d  Compares: %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rresp, er, "read response");
    chk(rdata, ed, "read data");
  endtask : axi_read

  function automatic logic [31:0] cw(input logic [1:0] im, input logic [1:0] wm,
                                     input logic [1:0] cm);
    cw = 32'h0000_0000;
    cw[adc_cmp_pkg::IRQ_MODE_LSB +: 2] = im;
    cw[adc_cmp_pkg::WMODE_LSB +: 2]    = wm;
    cw[adc_cmp_pkg::CMODE_LSB +: 2]    = cm;
  endfunction : cw

  function automatic logic hit(input logic [1:0] cm, input logic [11:0] r);
    logic inside_w;
    inside_w = (r >= LO) && (r <= HI);
    case (cm)
      2'h0:    hit = r < LO;
      2'h1:    hit = r > LO;
      2'h2:    hit = inside_w;
      default: hit = !inside_w;
    endcase
  endfunction : hit

  task automatic send(input logic [11:0] v, input logic es, input logic ei);
    @(posedge clock);
    result_valid <= 1'b1;
    result_data  <= v;
    @(posedge clock);
    result_valid <= 1'b0;
    #1;
    chk(store_strobe, es, "store strobe");
    chk(compare_irq, ei, "irq on result");
    if (es) chk(store_data, v, "store data");
  endtask : send

  task automatic scan(input logic ei);
    @(posedge clock);
    scan_done <= 1'b1;
    @(posedge clock);
    scan_done <= 1'b0;
    #1;
    chk(compare_irq, ei, "irq on scan");
  endtask : scan

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic e;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    axi_read(adc_cmp_pkg::CTRL_OFFSET, 32'h0000_0000, adc_cmp_pkg::RESP_OKAY);
    axi_write(adc_cmp_pkg::CTRL_OFFSET, 32'hFFFF_FFFF, adc_cmp_pkg::RESP_OKAY);
    axi_read(adc_cmp_pkg::CTRL_OFFSET, {16'h0000, adc_cmp_pkg::CTRL_WR_MASK},
             adc_cmp_pkg::RESP_OKAY);
    axi_write(adc_cmp_pkg::STATUS_OFFSET, 32'h0000_0000, adc_cmp_pkg::RESP_OKAY);
    axi_read(adc_cmp_pkg::CTRL_OFFSET, {16'h0000, adc_cmp_pkg::CTRL_WR_MASK},
             adc_cmp_pkg::RESP_OKAY);
    axi_write(32'h0000_0008, 32'h0000_0000, adc_cmp_pkg::RESP_SLVERR);
    axi_read(32'h0000_0008, 32'h0000_0000, adc_cmp_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      en  <= i[0];
      act <= i[1];
      repeat (2) @(posedge clock);
      #1;
      chk(bandgap_enable, i == 3, "band gap");
    end
    axi_read(adc_cmp_pkg::STATUS_OFFSET, 32'h0000_0004,
             adc_cmp_pkg::RESP_OKAY);
    axi_write(adc_cmp_pkg::CTRL_OFFSET, 32'h0000_0000, adc_cmp_pkg::RESP_OKAY);
    repeat (2) @(posedge clock);
    #1;
    chk(bandgap_enable, 0, "band gap off");
    for (int wm = 0; wm < 4; wm++) begin
      for (int cm = 0; cm < 4; cm++) begin
        axi_write(adc_cmp_pkg::CTRL_OFFSET, cw(2'h2, wm[1:0], cm[1:0]),
                  adc_cmp_pkg::RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
          e = hit(cm[1:0], vals[k]);
          send(vals[k], (wm == 0) || (wm == 1 && e), e);
        end
      end
    end
    foreach (vals[m]) begin
      if (m == 2) continue;
      axi_write(adc_cmp_pkg::CTRL_OFFSET, cw(m[1:0], 2'h2, 2'h0),
                adc_cmp_pkg::RESP_OKAY);
      scan(m == 1);
      send(12'h063, 1'b0, 1'b0);
      scan(m != 0);
      send(12'h096, 1'b0, 1'b0);
      scan(m == 1);
    end
    axi_write(adc_cmp_pkg::CTRL_OFFSET, cw(2'h3, 2'h2, 2'h0),
              adc_cmp_pkg::RESP_OKAY);
    @(posedge clock);
    result_valid <= 1'b1;
    result_data  <= 12'h063;
    scan_done    <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    scan_done    <= 1'b0;
    #1;
    chk(compare_irq, 1'b1, "irq on scan with match");
    axi_read(adc_cmp_pkg::STATUS_OFFSET, 32'h0000_0002,
             adc_cmp_pkg::RESP_OKAY);
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    stop_test();
  end
endmodule : adc_threshold_compare_control_bench
